//--- hw/stu_int_select.sv
`timescale 1ns/10ps
`default_nettype none
// picks one enabled delegated pending interrupt: external, software, timer
module stu_int_select (
  input wire logic [63:0] pending,
  input wire logic [63:0] enable,
  input wire logic [63:0] deleg,
  input wire logic globalEn,
  input wire logic [1:0] priv,
  output logic intValid,
  output logic [62:0] intCode
);
  logic [63:0] ready;
  logic allowed;
  // ------------------------------------------------------------
  // gating and choice
  // ------------------------------------------------------------
  always_comb begin
    ready = pending & enable & deleg & stu_pkg::INT_MASK;
    // taken in user mode always, in supervisor mode only with global enable
    allowed = (priv == stu_pkg::PRIV_USER) ||
      (priv == stu_pkg::PRIV_SUPER && globalEn);
    intValid = allowed && (ready != 64'h0);
    if (ready[stu_pkg::BIT_EXT]) begin
      intCode = stu_pkg::CODE_EXT;
    end else if (ready[stu_pkg::BIT_SOFT]) begin
      intCode = stu_pkg::CODE_SOFT;
    end else begin
      intCode = stu_pkg::CODE_TIMER;
    end
  end
endmodule : stu_int_select
`default_nettype wire

//--- hw/stu_vector_calc.sv
`timescale 1ns/10ps
`default_nettype none
// computes trap target: base, or base + 4 * code for vectored interrupts
module stu_vector_calc (
  input wire logic [63:0] vecReg,
  input wire logic isInt,
  input wire logic [62:0] code,
  output logic [63:0] target
);
  logic [63:0] base;
  // ------------------------------------------------------------
  // target select
  // ------------------------------------------------------------
  always_comb begin
    base = {vecReg[63:2], 2'h0};
    if (vecReg[1:0] == stu_pkg::MODE_VECTORED && isInt) begin
      target = base + {code[61:0], 2'h0};
    end else begin
      target = base;
    end
  end
endmodule : stu_vector_calc
`default_nettype wire

//--- hw/supervisor_trap_unit.sv
`timescale 1ns/10ps
`default_nettype none
module supervisor_trap_unit (
  input wire logic sys_clk,
  input wire logic rst,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // hart pipeline
  input wire logic [63:0] curPc,
  input wire logic excValid,
  input wire logic [62:0] cause_code,
  input wire logic trapReturn,
  input wire logic [63:0] retireAllowed,
  // interrupt sources (pins)
  input wire logic timerIntIn,
  input wire logic externalIntIn,
  // redirect to pipeline
  output logic redirectValid,
  output logic [63:0] redirectPc,
  output logic [1:0] privLevel
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic globalEn_q;
  logic priorEn_q;
  logic priorPriv_q;
  logic [1:0] priv_q;
  logic [63:0] intEnable_q;
  logic softPend_q;
  logic [63:0] cause_q;
  logic [63:0] vector_q;
  logic [63:0] epc_q;
  logic [63:0] intDeleg_q;
  logic [63:0] excDeleg_q;
  logic [1:0] timerSync_q;
  logic [1:0] extSync_q;
  logic injTimer_q;
  logic injExt_q;
  logic redirectValid_q;
  logic [63:0] redirectPc_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdata_q;
  stu_pkg::stu_bus_t busState_q;
  logic [63:0] pending;
  logic intValid;
  logic [62:0] intCode;
  logic excDelegated;
  logic takeInt;
  logic takeExc;
  logic trapEnter;
  logic trapIsInt;
  logic [62:0] trapCode;
  logic [63:0] trapTarget;
  logic busReq;
  logic wrStrobe;
  logic hit;
  logic [31:0] wmask;
  logic [31:0] vecLoNext;
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timerSync_q <= 2'h0;
      extSync_q <= 2'h0;
    end else begin
      timerSync_q <= {timerSync_q[0], timerIntIn};
      extSync_q <= {extSync_q[0], externalIntIn};
    end
  end
  // pending view: software flag stored, timer/external sampled or injected
  always_comb begin
    pending = 64'h0;
    pending[stu_pkg::BIT_SOFT] = softPend_q;
    pending[stu_pkg::BIT_TIMER] = timerSync_q[1] | injTimer_q;
    pending[stu_pkg::BIT_EXT] = extSync_q[1] | injExt_q;
  end
  // ------------------------------------------------------------
  // trap decision
  // ------------------------------------------------------------
  stu_int_select u_sel (
    .pending(pending),
    .enable(intEnable_q),
    .deleg(intDeleg_q),
    .globalEn(globalEn_q),
    .priv(priv_q),
    .intValid(intValid),
    .intCode(intCode)
  );
  always_comb begin
    excDelegated = (cause_code < 63'd64) &&
      excDeleg_q[cause_code[5:0]] && EXC_OK(cause_code);
    takeExc = excValid && excDelegated && (priv_q != stu_pkg::PRIV_MACHINE);
    takeInt = intValid && !excValid && retireAllowed[0];
    trapEnter = takeExc || takeInt;
    trapIsInt = takeInt;
    trapCode = takeInt ? intCode : cause_code;
  end
  function automatic logic EXC_OK(input logic [62:0] c);
    logic [63:0] m;
    m = stu_pkg::EXC_MASK;
    EXC_OK = (c < 63'd16) && m[c[5:0]];
  endfunction : EXC_OK
  stu_vector_calc u_vec (
    .vecReg(vector_q),
    .isInt(trapIsInt),
    .code(trapCode),
    .target(trapTarget)
  );
  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  always_comb begin
    busReq = wb_cyc_i && wb_stb_i && (busState_q == stu_pkg::STU_IDLE);
    wrStrobe = busReq && wb_we_i;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    case (wb_adr_i)
      stu_pkg::ADDR_STATUS, stu_pkg::ADDR_INT_ENABLE, stu_pkg::ADDR_PENDING,
      stu_pkg::ADDR_CAUSE_LO, stu_pkg::ADDR_CAUSE_HI, stu_pkg::ADDR_VECTOR_LO,
      stu_pkg::ADDR_VECTOR_HI, stu_pkg::ADDR_EPC_LO, stu_pkg::ADDR_EPC_HI,
      stu_pkg::ADDR_INT_DELEG, stu_pkg::ADDR_EXC_DELEG, stu_pkg::ADDR_PRIV,
      stu_pkg::ADDR_PEND_SET: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  // merge helper for byte lanes
  function automatic logic [31:0] MERGE(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    MERGE = (old & ~m) | (nw & m);
  endfunction : MERGE
  // ------------------------------------------------------------
  // status, privilege, trap entry and return
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      globalEn_q <= 1'b0;
      priorEn_q <= 1'b0;
      priorPriv_q <= 1'b0;
      priv_q <= stu_pkg::PRIV_MACHINE;
    end else if (trapEnter) begin
      priorEn_q <= globalEn_q;
      globalEn_q <= 1'b0;
      priorPriv_q <= (priv_q == stu_pkg::PRIV_SUPER);
      priv_q <= stu_pkg::PRIV_SUPER;
    end else if (trapReturn) begin
      priv_q <= priorPriv_q ? stu_pkg::PRIV_SUPER : stu_pkg::PRIV_USER;
      globalEn_q <= priorEn_q;
      priorEn_q <= 1'b1;
      priorPriv_q <= 1'b0;
    end else if (wrStrobe && wb_adr_i == stu_pkg::ADDR_STATUS) begin
      if (wb_sel_i[0]) begin
        globalEn_q <= wb_dat_i[stu_pkg::BIT_GIE];
        priorEn_q <= wb_dat_i[stu_pkg::BIT_PIE];
      end
      if (wb_sel_i[1]) begin
        priorPriv_q <= wb_dat_i[stu_pkg::BIT_PPRIV];
      end
    end else if (wrStrobe && wb_adr_i == stu_pkg::ADDR_PRIV && wb_sel_i[0]) begin
      priv_q <= wb_dat_i[1:0];
    end
  end
  // cause and saved pc
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cause_q <= 64'h0;
      epc_q <= 64'h0;
    end else if (trapEnter) begin
      cause_q <= {trapIsInt, trapCode};
      epc_q <= curPc;
    end else if (wrStrobe) begin
      if (wb_adr_i == stu_pkg::ADDR_CAUSE_LO)
        cause_q[31:0] <= MERGE(cause_q[31:0], wb_dat_i, wmask);
      if (wb_adr_i == stu_pkg::ADDR_CAUSE_HI)
        cause_q[63:32] <= MERGE(cause_q[63:32], wb_dat_i, wmask);
      if (wb_adr_i == stu_pkg::ADDR_EPC_LO) epc_q[31:0] <= MERGE(epc_q[31:0], wb_dat_i, wmask);
      if (wb_adr_i == stu_pkg::ADDR_EPC_HI) epc_q[63:32] <= MERGE(epc_q[63:32], wb_dat_i, wmask);
    end
  end
  // low vector word after byte-lane merge; its two low bits are not stored as base
  assign vecLoNext = MERGE(vector_q[31:0], wb_dat_i, wmask);
  // vector register, reserved modes fall back to direct
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vector_q <= 64'h0;
    end else if (wrStrobe && wb_adr_i == stu_pkg::ADDR_VECTOR_LO) begin
      vector_q[31:2] <= vecLoNext[31:2];
      if (wb_sel_i[0]) begin
        vector_q[1:0] <= (wb_dat_i[1:0] == stu_pkg::MODE_VECTORED) ?
          stu_pkg::MODE_VECTORED : stu_pkg::MODE_DIRECT;
      end
    end else if (wrStrobe && wb_adr_i == stu_pkg::ADDR_VECTOR_HI) begin
      vector_q[63:32] <= MERGE(vector_q[63:32], wb_dat_i, wmask);
    end
  end
  // enables, delegation, software pending and injection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intEnable_q <= 64'h0;
      intDeleg_q <= 64'h0;
      excDeleg_q <= 64'h0;
      softPend_q <= 1'b0;
      injTimer_q <= 1'b0;
      injExt_q <= 1'b0;
    end else if (wrStrobe) begin
      if (wb_adr_i == stu_pkg::ADDR_INT_ENABLE)
        intEnable_q <= {32'h0, MERGE(intEnable_q[31:0], wb_dat_i, wmask)} & stu_pkg::INT_MASK;
      if (wb_adr_i == stu_pkg::ADDR_INT_DELEG)
        intDeleg_q <= {32'h0, MERGE(intDeleg_q[31:0], wb_dat_i, wmask)} & stu_pkg::INT_MASK;
      if (wb_adr_i == stu_pkg::ADDR_EXC_DELEG)
        excDeleg_q <= {32'h0, MERGE(excDeleg_q[31:0], wb_dat_i, wmask)} & stu_pkg::EXC_MASK;
      if (wb_adr_i == stu_pkg::ADDR_PENDING && wb_sel_i[0])
        softPend_q <= wb_dat_i[stu_pkg::BIT_SOFT];
      if (wb_adr_i == stu_pkg::ADDR_PEND_SET && wb_sel_i[0])
        softPend_q <= softPend_q | wb_dat_i[stu_pkg::BIT_SOFT];
      if (wb_adr_i == stu_pkg::ADDR_PEND_SET || wb_adr_i == stu_pkg::ADDR_PENDING) begin
        if (wb_sel_i[0]) injTimer_q <= wb_dat_i[stu_pkg::BIT_TIMER];
        if (wb_sel_i[1]) injExt_q <= wb_dat_i[stu_pkg::BIT_EXT];
      end
    end
  end
  // ------------------------------------------------------------
  // redirect output
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      redirectValid_q <= 1'b0;
      redirectPc_q <= 64'h0;
    end else if (trapEnter) begin
      redirectValid_q <= 1'b1;
      redirectPc_q <= trapTarget;
    end else if (trapReturn) begin
      redirectValid_q <= 1'b1;
      redirectPc_q <= epc_q;
    end else begin
      redirectValid_q <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // bus answer, one wait state
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busState_q <= stu_pkg::STU_IDLE;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= stu_pkg::RESET_ZERO;
    end else begin
      case (busState_q)
        stu_pkg::STU_IDLE: begin
          ack_q <= busReq && hit;
          err_q <= busReq && !hit;
          if (busReq) busState_q <= stu_pkg::STU_ACK;
          case (wb_adr_i)
            stu_pkg::ADDR_STATUS:
              rdata_q <= {23'h0, priorPriv_q, 2'h0, priorEn_q, 3'h0, globalEn_q, 1'b0};
            stu_pkg::ADDR_INT_ENABLE: rdata_q <= intEnable_q[31:0];
            stu_pkg::ADDR_PENDING, stu_pkg::ADDR_PEND_SET: rdata_q <= pending[31:0];
            stu_pkg::ADDR_CAUSE_LO: rdata_q <= cause_q[31:0];
            stu_pkg::ADDR_CAUSE_HI: rdata_q <= cause_q[63:32];
            stu_pkg::ADDR_VECTOR_LO: rdata_q <= vector_q[31:0];
            stu_pkg::ADDR_VECTOR_HI: rdata_q <= vector_q[63:32];
            stu_pkg::ADDR_EPC_LO: rdata_q <= epc_q[31:0];
            stu_pkg::ADDR_EPC_HI: rdata_q <= epc_q[63:32];
            stu_pkg::ADDR_INT_DELEG: rdata_q <= intDeleg_q[31:0];
            stu_pkg::ADDR_EXC_DELEG: rdata_q <= excDeleg_q[31:0];
            stu_pkg::ADDR_PRIV: rdata_q <= {30'h0, priv_q};
            default: rdata_q <= stu_pkg::RESET_ZERO;
          endcase
        end
        stu_pkg::STU_ACK: begin
          ack_q <= 1'b0;
          err_q <= 1'b0;
          busState_q <= stu_pkg::STU_IDLE;
        end
        default: busState_q <= stu_pkg::STU_IDLE;
      endcase
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;
  assign redirectValid = redirectValid_q;
  assign redirectPc = redirectPc_q;
  assign privLevel = priv_q;
endmodule : supervisor_trap_unit
`default_nettype wire

//--- include/stu_pkg.sv
`default_nettype none
package stu_pkg;
  // ------------------------------------------------------------
  // register map (word offsets are byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_PENDING = 8'h08;
  localparam logic [7:0] ADDR_CAUSE_LO = 8'h0C;
  localparam logic [7:0] ADDR_CAUSE_HI = 8'h10;
  localparam logic [7:0] ADDR_VECTOR_LO = 8'h14;
  localparam logic [7:0] ADDR_VECTOR_HI = 8'h18;
  localparam logic [7:0] ADDR_EPC_LO = 8'h1C;
  localparam logic [7:0] ADDR_EPC_HI = 8'h20;
  localparam logic [7:0] ADDR_INT_DELEG = 8'h24;
  localparam logic [7:0] ADDR_EXC_DELEG = 8'h28;
  localparam logic [7:0] ADDR_PRIV = 8'h2C;
  localparam logic [7:0] ADDR_PEND_SET = 8'h30;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_SOFT = 1;
  localparam int BIT_TIMER = 5;
  localparam int BIT_EXT = 9;
  localparam int BIT_GIE = 1;
  localparam int BIT_PIE = 5;
  localparam int BIT_PPRIV = 8;
  localparam int CAUSE_INT_BIT = 63;
  localparam logic [63:0] INT_MASK = 64'h0000_0000_0000_0222;
  localparam logic [63:0] EXC_MASK = 64'h0000_0000_0000_B1EF;
  localparam logic [62:0] CODE_SOFT = 63'h1;
  localparam logic [62:0] CODE_TIMER = 63'h5;
  localparam logic [62:0] CODE_EXT = 63'h9;
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] MODE_VECTORED = 2'h1;
  localparam logic [1:0] PRIV_USER = 2'h0;
  localparam logic [1:0] PRIV_SUPER = 2'h1;
  localparam logic [1:0] PRIV_MACHINE = 2'h3;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {STU_IDLE, STU_ACK} stu_bus_t;
endpackage : stu_pkg
`default_nettype wire

//--- verif/stu_hart_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// hart pipeline and pin model
// ------------------------------
module stu_hart_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic redirectValid,
  input wire logic [63:0] redirectPc,
  output logic [63:0] curPc,
  output logic excValid,
  output logic [62:0] cause_code,
  output logic trapReturn,
  output logic [63:0] retireAllowed,
  output logic timerIntIn,
  output logic externalIntIn
);
  // idle levels at time zero, retire always allowed
  initial begin
    excValid = 1'b0;
    cause_code = 63'h0;
    trapReturn = 1'b0;
    retireAllowed = 64'h1;
    timerIntIn = 1'b0;
    externalIntIn = 1'b0;
  end
  // pc steps a word per cycle and follows redirects
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      curPc <= 64'h8000;
    end else if (redirectValid) begin
      curPc <= redirectPc;
    end else begin
      curPc <= curPc + 64'h4;
    end
  end
  task automatic raise_exc(input logic [62:0] code);
    @(posedge sys_clk);
    excValid <= 1'b1;
    cause_code <= code;
    @(posedge sys_clk);
    excValid <= 1'b0;
    cause_code <= ~code; // stale code is not left standing
  endtask : raise_exc
  task automatic do_return();
    @(posedge sys_clk);
    trapReturn <= 1'b1;
    @(posedge sys_clk);
    trapReturn <= 1'b0;
  endtask : do_return
  task automatic set_pins(input logic t, input logic e);
    @(posedge sys_clk);
    timerIntIn <= t;
    externalIntIn <= e;
  endtask : set_pins
endmodule : stu_hart_model
`default_nettype wire

//--- verif/stu_trap_props.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// port checker
// ------------------------------
module stu_trap_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic excValid,
  input wire logic trapReturn,
  input wire logic redirectValid,
  input wire logic [63:0] redirectPc,
  input wire logic [1:0] privLevel
);
  // one clock domain, reset disables every check
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o != wb_err_o) else $error("bus request not answered once");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  map_err_a: assert property (wb_ack_o || wb_err_o
    |-> wb_err_o == ($past(wb_adr_i) > stu_pkg::ADDR_PEND_SET ||
    $past(wb_adr_i[1:0]) != 2'h0)) else $error("bad error answer");
  reset_state_a: assert property ($past(rst) |-> privLevel == stu_pkg::PRIV_MACHINE
    && !redirectValid) else $error("wrong state after reset");
  target_align_a: assert property (redirectValid && !$past(trapReturn)
    |-> redirectPc[1:0] == 2'h0) else $error("trap target not word aligned");
  trap_priv_a: assert property (redirectValid && !$past(trapReturn)
    |-> privLevel == stu_pkg::PRIV_SUPER) else $error("trap did not enter supervisor");
  machine_quiet_a: assert property (privLevel == stu_pkg::PRIV_MACHINE && !trapReturn
    |=> !redirectValid) else $error("redirect out of machine mode");
  return_redir_a: assert property (trapReturn && !excValid |=> redirectValid)
    else $error("return gave no redirect");
endmodule : stu_trap_props
bind supervisor_trap_unit stu_trap_props stu_trap_props_i (.sys_clk(sys_clk), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .excValid(excValid), .trapReturn(trapReturn),
  .redirectValid(redirectValid), .redirectPc(redirectPc), .privLevel(privLevel));
`default_nettype wire

//--- verif/supervisor_trap_unit_test.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// trap unit bench
// ------------------------------
module supervisor_trap_unit_test;
  logic sys_clk;
  logic rst;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [31:0] datW;
  logic [31:0] datR;
  logic ack;
  logic err;
  logic errSeen;
  logic [63:0] curPc;
  logic excValid;
  logic [62:0] cause_code;
  logic trapRet;
  logic [63:0] retire;
  logic tIn;
  logic eIn;
  logic redV;
  logic [63:0] redPc;
  logic [1:0] priv;
  logic [31:0] rd;
  logic [63:0] pc;
  logic [63:0] tPc;
  logic [7:0] codes [0:10] = '{8'h0, 8'h1, 8'h2, 8'h3, 8'h5, 8'h6, 8'h7, 8'h8, 8'hC, 8'hD, 8'hF};
  int error_cnt = 0;
  int checked = 0;
  supervisor_trap_unit supervisor_trap_unit_i (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datW),
    .wb_dat_o(datR), .wb_ack_o(ack), .wb_err_o(err), .curPc(curPc), .excValid(excValid),
    .cause_code(cause_code), .trapReturn(trapRet), .retireAllowed(retire), .timerIntIn(tIn),
    .externalIntIn(eIn), .redirectValid(redV), .redirectPc(redPc), .privLevel(priv));
  stu_hart_model stu_hart_model_i (.sys_clk(sys_clk), .rst(rst), .redirectValid(redV),
    .redirectPc(redPc), .curPc(curPc), .excValid(excValid), .cause_code(cause_code),
    .trapReturn(trapRet), .retireAllowed(retire), .timerIntIn(tIn), .externalIntIn(eIn));
  // free running clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {cyc, stb, we, adr, datW} <= {2'b11, w, a, d};
    for (n = 0; n < 20 && ack !== 1'b1 && err !== 1'b1; n++) @(posedge sys_clk);
    rd = datR;
    errSeen = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1 && err !== 1'b1) begin
      error_cnt++;
      close_out();
    end
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(64'(rd), 64'(exp));
  endtask : rdchk
  task automatic wait_redir();
    int n;
    for (n = 0; n < 40 && redV !== 1'b1; n++) @(posedge sys_clk);
    if (redV !== 1'b1) begin
      error_cnt++;
      close_out();
    end
    pc = redPc;
    tPc = curPc - 64'h4; // pc of the cycle the trap was taken
  endtask : wait_redir
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      chk(64'(redV), 64'h0);
    end
  endtask : quiet
  task automatic ret_to(input logic [63:0] epc, input logic [1:0] p);
    stu_hart_model_i.do_return();
    wait_redir();
    chk(pc, epc);
    chk(64'(priv), 64'(p));
  endtask : ret_to
  task automatic s_pending();
    wr(stu_pkg::ADDR_PENDING, 32'hFFFF_FFFF);
    rdchk(stu_pkg::ADDR_PENDING, 32'h0000_0222);
    wr(stu_pkg::ADDR_PENDING, 32'h0);
    rdchk(stu_pkg::ADDR_PENDING, 32'h0);
    wb(1'b0, 8'hFC, 32'h0);
    chk(64'(errSeen), 64'h1);
  endtask : s_pending
  task automatic s_exceptions();
    wr(stu_pkg::ADDR_VECTOR_LO, 32'h0000_1002);
    rdchk(stu_pkg::ADDR_VECTOR_LO, 32'h0000_1000);
    wr(stu_pkg::ADDR_PRIV, 32'h0);
    for (int i = 0; i < 11; i++) begin
      stu_hart_model_i.raise_exc(63'(codes[i]));
      wait_redir();
      chk(pc, 64'h1000);
      rdchk(stu_pkg::ADDR_CAUSE_LO, 32'(codes[i]));
      rdchk(stu_pkg::ADDR_CAUSE_HI, 32'h0);
      rdchk(stu_pkg::ADDR_EPC_LO, tPc[31:0]);
      ret_to(tPc, stu_pkg::PRIV_USER);
    end
    stu_hart_model_i.raise_exc(63'h4);
    quiet(10);
  endtask : s_exceptions
  task automatic int_case(input int kind, input logic [62:0] code);
    stu_hart_model_i.set_pins(kind == 0, kind == 1);
    wait_redir();
    chk(pc, 64'h2000 + 64'(code) * 64'h4);
    rdchk(stu_pkg::ADDR_CAUSE_LO, 32'(code));
    rdchk(stu_pkg::ADDR_CAUSE_HI, 32'h8000_0000);
    rdchk(stu_pkg::ADDR_STATUS, 32'h0000_0020);
    rdchk(stu_pkg::ADDR_EPC_LO, tPc[31:0]);
    stu_hart_model_i.set_pins(1'b0, 1'b0);
    ret_to(tPc, stu_pkg::PRIV_USER);
  endtask : int_case
  task automatic s_reenable();
    wr(stu_pkg::ADDR_PEND_SET, 32'h2);
    wait_redir();
    chk(pc, 64'h2004);
    quiet(8);
    wr(stu_pkg::ADDR_STATUS, 32'h2);
    wait_redir();
    chk(pc, 64'h2004);
    rdchk(stu_pkg::ADDR_CAUSE_LO, 32'h1);
    rdchk(stu_pkg::ADDR_STATUS, 32'h0000_0120);
    wr(stu_pkg::ADDR_PENDING, 32'h0);
    ret_to(tPc, stu_pkg::PRIV_SUPER);
  endtask : s_reenable
  // reset, delegation setup, then the scenarios
  initial begin
    {rst, cyc, stb, we, adr, datW} = {4'b1000, 8'h0, 32'h0};
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    wr(stu_pkg::ADDR_INT_DELEG, 32'h0000_0222);
    wr(stu_pkg::ADDR_EXC_DELEG, stu_pkg::EXC_MASK[31:0]);
    s_pending();
    s_exceptions();
    wr(stu_pkg::ADDR_VECTOR_LO, 32'h0000_2001);
    wr(stu_pkg::ADDR_STATUS, 32'h2);
    wr(stu_pkg::ADDR_INT_ENABLE, 32'h0000_0200);
    stu_hart_model_i.set_pins(1'b1, 1'b0);
    quiet(10);
    stu_hart_model_i.set_pins(1'b0, 1'b0);
    quiet(4);
    wr(stu_pkg::ADDR_INT_ENABLE, 32'h0000_0222);
    int_case(0, stu_pkg::CODE_TIMER);
    int_case(1, stu_pkg::CODE_EXT);
    s_reenable();
    close_out();
  end
endmodule : supervisor_trap_unit_test
`default_nettype wire
